// [ppde_pkg.sv]
// Constants and types shared by the parallel port blocks
package ppde_pkg;
    localparam int         PORT_W         = 8;
    localparam int         IO_ADDR_W      = 16;
    localparam int         SLICE_W        = 3;
    localparam int         IRQ_LINES      = 4;
    localparam int         WARM_W         = 2;
    localparam logic [7:0] PORT_RST       = 8'h00;
    localparam logic [7:0] STROBE_IDLE    = 8'hFF;
    localparam logic [1:0] WARM_DONE      = 2'h3;
    localparam int         ALT_TX_A_BIT   = 6;
    localparam int         ALT_TX_B_BIT   = 4;
    localparam int         ALT_RX_A_BIT   = 7;
    localparam int         ALT_RX_B_BIT   = 5;
    localparam int         SLAVE_CS_BIT   = 7;
    localparam int         IRQ0_A_BIT     = 0;
    localparam int         IRQ0_B_BIT     = 4;
    localparam int         IRQ1_A_BIT     = 1;
    localparam int         IRQ1_B_BIT     = 5;

    typedef enum logic [1:0] {
        PPDE_EDGE_OFF,
        PPDE_EDGE_FALL,
        PPDE_EDGE_RISE,
        PPDE_EDGE_BOTH
    } ppde_edge_t;

    typedef enum logic [1:0] {
        PPDE_STB_CS,
        PPDE_STB_WR,
        PPDE_STB_RD,
        PPDE_STB_RW
    } ppde_stb_mode_t;
endpackage

// [ppde_irq_if.sv]
// Link between the port top and one interrupt edge detector
interface ppde_irq_if;
    logic                  en;
    ppde_pkg::ppde_edge_t  edge_sel;
    logic                  level;
    logic                  clr;
    logic                  pend;

    modport det (input en, input edge_sel, input level, input clr, output pend);
    modport ctl (output en, output edge_sel, output level, output clr, input pend);
endinterface

// [ppde_edge_det.sv]
// Synchroniser, edge detector and pending latch for one interrupt input
module ppde_edge_det (
    input  wire logic   i_core_clk,
    input  wire logic   i_rst_n,
    ppde_irq_if.det     irq
);
    typedef struct packed {
        logic                          s1;
        logic                          s2;
        logic                          prev;
        logic [ppde_pkg::WARM_W-1:0]   warm;
        logic                          pend;
    } ppde_det_state_t;

    ppde_det_state_t st_reg;
    ppde_det_state_t st_next;
    logic            rise;
    logic            fall;
    logic            hit;

    always_comb begin
        st_next      = st_reg;
        st_next.s1   = irq.level;
        st_next.s2   = st_reg.s1;
        st_next.prev = st_reg.s2;
        if (st_reg.warm != ppde_pkg::WARM_DONE) begin
            st_next.warm = st_reg.warm + 2'h1;
        end
        rise = st_reg.s2 && !st_reg.prev;
        fall = !st_reg.s2 && st_reg.prev;
        unique case (irq.edge_sel)
            ppde_pkg::PPDE_EDGE_OFF:  hit = 1'b0;
            ppde_pkg::PPDE_EDGE_FALL: hit = fall;
            ppde_pkg::PPDE_EDGE_RISE: hit = rise;
            ppde_pkg::PPDE_EDGE_BOTH: hit = rise || fall;
        endcase
        hit = hit && irq.en && (st_reg.warm == ppde_pkg::WARM_DONE);
        // Set wins over a clear in the same cycle
        if (hit) begin
            st_next.pend = 1'b1;
        end else if (irq.clr) begin
            st_next.pend = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign irq.pend = st_reg.pend;

    a_pend_held: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_reg.pend && !irq.clr |=> st_reg.pend)
        else $error("pending request dropped without clear");

    a_edge_latched: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        irq.en && irq.edge_sel == ppde_pkg::PPDE_EDGE_RISE
        && st_reg.warm == ppde_pkg::WARM_DONE && st_reg.s2 && !st_reg.prev |=> st_reg.pend)
        else $error("rising edge not latched");

    a_off_no_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        !st_reg.pend && !irq.en |=> !st_reg.pend)
        else $error("request set while input disabled");
endmodule // ppde_edge_det

// [ppde_top.sv]
// Two parallel ports with open drain, serial, strobe, slave select and interrupt functions

// Summary of operation
// - Open-drain port bits have own direction
// - Each open-drain port output bit push-pull or open drain
// - Output registers reload on timer event
// - Bits 6 and 4 carry alternate transmit
// - Bits 7 and 5 feed alternate receive
// - Strobe port bits may output strobes
// - Eight strobes, one per address eighth
// - Strobe modes: select, write, read, both
// - Bit 7 is slave chip select
// - Bit 7 output low forces select
// - Bits 0,4 and 1,5 feed interrupts
// - Edge selectable: fall, rise or both
// - Paired detections ORed into one request
// - Each interrupt input latches its edge
// - Each strobe decodes an 8K block
module ppde_top #(
    parameter int PORT_W    = ppde_pkg::PORT_W,
    parameter int IO_ADDR_W = ppde_pkg::IO_ADDR_W
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_nrst,
    input  wire logic                   i_timer_evt,
    input  wire logic [PORT_W-1:0]      i_od_dir,
    input  wire logic [PORT_W-1:0]      i_od_opendrain,
    input  wire logic [PORT_W-1:0]      i_od_wr_data,
    input  wire logic                   i_od_wr,
    input  wire logic                   i_od_timed,
    input  wire logic                   i_alt_tx_a_en,
    input  wire logic                   i_alt_tx_b_en,
    input  wire logic                   i_alt_tx_chan_a,
    input  wire logic                   i_alt_tx_chan_b,
    input  wire logic [PORT_W-1:0]      i_od_port_bits,
    output logic      [PORT_W-1:0]      o_od_port_bits,
    output logic      [PORT_W-1:0]      o_od_port_bits_oe,
    output logic      [PORT_W-1:0]      o_od_rd_data,
    output logic                        o_alt_rx_chan_a,
    output logic                        o_alt_rx_chan_b,
    input  wire logic [PORT_W-1:0]      i_se_dir,
    input  wire logic [PORT_W-1:0]      i_se_wr_data,
    input  wire logic                   i_se_wr,
    input  wire logic                   i_se_timed,
    input  wire logic [PORT_W-1:0]      i_strobe_en,
    input  wire logic [2*PORT_W-1:0]    i_strobe_mode,
    input  wire logic                   i_io_cycle,
    input  wire logic                   i_io_rd,
    input  wire logic                   i_io_wr,
    input  wire logic [IO_ADDR_W-1:0]   i_io_addr,
    input  wire logic [PORT_W-1:0]      i_strobe_port_bits,
    output logic      [PORT_W-1:0]      o_strobe_port_bits,
    output logic      [PORT_W-1:0]      o_strobe_port_bits_oe,
    output logic      [PORT_W-1:0]      o_se_rd_data,
    input  wire logic                   i_slave_en,
    output logic                        o_slave_chip_select_n,
    input  wire logic                   i_ext_irq0_in_a_en,
    input  wire logic                   i_ext_irq0_in_b_en,
    input  wire logic                   i_ext_irq1_in_a_en,
    input  wire logic                   i_ext_irq1_in_b_en,
    input  wire logic [1:0]             i_irq0_edge,
    input  wire logic [1:0]             i_irq1_edge,
    input  wire logic                   i_irq0_clr,
    input  wire logic                   i_irq1_clr,
    output logic                        o_irq0_req,
    output logic                        o_irq1_req
);
    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [PORT_W-1:0] od_shadow;
        logic [PORT_W-1:0] od_out;
        logic [PORT_W-1:0] se_shadow;
        logic [PORT_W-1:0] se_out;
        logic [PORT_W-1:0] strobe_n;
    } ppde_state_t;

    ppde_state_t st_reg;
    ppde_state_t st_next;

    function automatic logic strobe_hit(input logic [1:0] mode, input logic rd, input logic wr);
        unique case (ppde_pkg::ppde_stb_mode_t'(mode))
            ppde_pkg::PPDE_STB_CS: strobe_hit = 1'b1;
            ppde_pkg::PPDE_STB_WR: strobe_hit = wr;
            ppde_pkg::PPDE_STB_RD: strobe_hit = rd;
            ppde_pkg::PPDE_STB_RW: strobe_hit = rd || wr;
        endcase
    endfunction

    logic [ppde_pkg::SLICE_W-1:0] slice;
    assign slice = i_io_addr[IO_ADDR_W-1 -: ppde_pkg::SLICE_W];

    always_comb begin
        st_next = st_reg;
        if (i_od_wr) begin
            st_next.od_shadow = i_od_wr_data;
        end
        if (i_se_wr) begin
            st_next.se_shadow = i_se_wr_data;
        end
        // Second stage follows at once, or only on the timer event
        if (!i_od_timed || i_timer_evt) begin
            st_next.od_out = st_next.od_shadow;
        end
        if (!i_se_timed || i_timer_evt) begin
            st_next.se_out = st_next.se_shadow;
        end
        for (int k = 0; k < PORT_W; k++) begin
            st_next.strobe_n[k] = !(i_io_cycle && slice == k[ppde_pkg::SLICE_W-1:0]
                && strobe_hit(i_strobe_mode[2*k +: 2], i_io_rd, i_io_wr));
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.od_shadow <= ppde_pkg::PORT_RST;
            st_reg.od_out    <= ppde_pkg::PORT_RST;
            st_reg.se_shadow <= ppde_pkg::PORT_RST;
            st_reg.se_out    <= ppde_pkg::PORT_RST;
            st_reg.strobe_n  <= ppde_pkg::STROBE_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Open-drain capable port
    // ****************************************
    logic [PORT_W-1:0] od_val;

    always_comb begin
        od_val = st_reg.od_out;
        if (i_alt_tx_a_en) begin
            od_val[ppde_pkg::ALT_TX_A_BIT] = i_alt_tx_chan_a;
        end
        if (i_alt_tx_b_en) begin
            od_val[ppde_pkg::ALT_TX_B_BIT] = i_alt_tx_chan_b;
        end
    end

    // Open drain only pulls low, so data line stays low and enable carries the inverted bit
    assign o_od_port_bits    = od_val & ~i_od_opendrain;
    assign o_od_port_bits_oe = i_od_dir & ~(i_od_opendrain & od_val);
    assign o_od_rd_data      = i_od_port_bits;
    assign o_alt_rx_chan_a   = i_od_port_bits[ppde_pkg::ALT_RX_A_BIT];
    assign o_alt_rx_chan_b   = i_od_port_bits[ppde_pkg::ALT_RX_B_BIT];

    // ****************************************
    // Strobe capable port
    // ****************************************
    logic [PORT_W-1:0] se_eff;

    assign o_strobe_port_bits    = (i_strobe_en & st_reg.strobe_n)
                                 | (~i_strobe_en & st_reg.se_out);
    assign o_strobe_port_bits_oe = i_se_dir;
    assign o_se_rd_data          = i_strobe_port_bits;
    assign se_eff                = (i_se_dir & o_strobe_port_bits) | (~i_se_dir & i_strobe_port_bits);
    assign o_slave_chip_select_n = !i_slave_en || se_eff[ppde_pkg::SLAVE_CS_BIT];

    // ****************************************
    // External interrupts
    // ****************************************
    localparam int IRQ_BIT [ppde_pkg::IRQ_LINES] = '{ppde_pkg::IRQ0_A_BIT, ppde_pkg::IRQ0_B_BIT,
                                                    ppde_pkg::IRQ1_A_BIT, ppde_pkg::IRQ1_B_BIT};
    logic [ppde_pkg::IRQ_LINES-1:0] irq_en;
    logic [ppde_pkg::IRQ_LINES-1:0] irq_pend;

    assign irq_en = {i_ext_irq1_in_b_en, i_ext_irq1_in_a_en,
                     i_ext_irq0_in_b_en, i_ext_irq0_in_a_en};

    generate
        for (genvar g = 0; g < ppde_pkg::IRQ_LINES; g++) begin : g_irq
            ppde_irq_if irq_link ();
            assign irq_link.en       = irq_en[g];
            assign irq_link.edge_sel = ppde_pkg::ppde_edge_t'(g < 2 ? i_irq0_edge : i_irq1_edge);
            // Driven output bits may also raise the request
            assign irq_link.level    = se_eff[IRQ_BIT[g]];
            assign irq_link.clr      = (g < 2) ? i_irq0_clr : i_irq1_clr;
            assign irq_pend[g]       = irq_link.pend;
            ppde_edge_det u_det (
                .i_core_clk (i_core_clk),
                .i_rst_n    (rst_n),
                .irq        (irq_link)
            );
        end
    endgenerate

    assign o_irq0_req = irq_pend[0] || irq_pend[1];
    assign o_irq1_req = irq_pend[2] || irq_pend[3];

    // ****************************************
    // Checks
    // ****************************************
    a_od_dir_input: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (o_od_port_bits_oe & ~i_od_dir) == 8'h00)
        else $error("input bit of open-drain port driven");

    a_od_no_high: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        (o_od_port_bits_oe & i_od_opendrain & od_val) == 8'h00)
        else $error("open-drain bit driven high");

    a_timed_hold: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_od_timed && !i_timer_evt |=> $stable(st_reg.od_out))
        else $error("timed output changed without timer event");

    a_timed_load: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_se_timed && i_timer_evt |=> st_reg.se_out == st_reg.se_shadow)
        else $error("timed output not loaded on timer event");

    a_alt_tx_path: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_alt_tx_a_en && !i_od_opendrain[ppde_pkg::ALT_TX_A_BIT]
        |-> o_od_port_bits[ppde_pkg::ALT_TX_A_BIT] == i_alt_tx_chan_a)
        else $error("alternate transmit A not on bit 6");

    a_strobe_write: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        !i_io_wr && i_strobe_mode[1:0] == 2'h1 |=> st_reg.strobe_n[0])
        else $error("write strobe fired without write");

    a_slave_forced: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        i_slave_en && i_se_dir[ppde_pkg::SLAVE_CS_BIT]
        && !o_strobe_port_bits[ppde_pkg::SLAVE_CS_BIT] |-> !o_slave_chip_select_n)
        else $error("slave select not forced by low output");

    a_slave_off: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        !i_slave_en |-> o_slave_chip_select_n)
        else $error("slave select active while disabled");

    a_irq_or: assert property (@(posedge i_core_clk) disable iff (!rst_n)
        o_irq1_req == (g_irq[2].irq_link.pend || g_irq[3].irq_link.pend))
        else $error("interrupt 1 request not the OR of its inputs");

    generate
        for (genvar s = 0; s < PORT_W; s++) begin : g_chk
            a_strobe_slice: assert property (@(posedge i_core_clk) disable iff (!rst_n)
                !st_reg.strobe_n[s] |-> $past(i_io_cycle) && $past(slice) == s)
                else $error("strobe active outside its address slice");
        end
    endgenerate
endmodule // ppde_top

// [ppde_pin_model.sv]
// Board model around both ports: external drivers and pull-ups
module ppde_pin_model (
    input  wire logic [7:0] i_dut_val,
    input  wire logic [7:0] i_dut_oe,
    input  wire logic [7:0] i_ext_val,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_pin
);
    // ****************
    // Pin resolution
    // ****************
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (i_dut_oe[b]) begin
                o_pin[b] = i_dut_val[b];
            end else if (i_ext_en[b]) begin
                o_pin[b] = i_ext_val[b];
            end else begin
                o_pin[b] = 1'b1;
            end
        end
    end
endmodule // ppde_pin_model

// [tb_top.sv]
// Self-checking bench for the two parallel ports
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, nrst, tevt, od_wr, od_timed, txa_en, txb_en, txa, txb;
    logic        se_wr, se_timed, io_cyc, io_rd, io_wr, slv_en, clr0, clr1;
    logic        e0a, e0b, e1a, e1b, rxa, rxb, scs_n, req0, req1;
    logic [1:0]  edg0, edg1;
    logic [7:0]  od_dir, od_odr, od_dat, od_pin, od_out, od_oe, od_rd, ext_od, ext_od_en;
    logic [7:0]  se_dir, se_dat, stb_en, se_pin, se_out, se_oe, se_rd, ext_se, ext_se_en;
    logic [15:0] stb_mode, io_addr;
    int          n_fail, checks;
    logic        act;
    ppde_top u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_timer_evt(tevt), .i_od_dir(od_dir),
        .i_od_opendrain(od_odr), .i_od_wr_data(od_dat), .i_od_wr(od_wr),
        .i_od_timed(od_timed), .i_alt_tx_a_en(txa_en), .i_alt_tx_b_en(txb_en),
        .i_alt_tx_chan_a(txa), .i_alt_tx_chan_b(txb), .i_od_port_bits(od_pin),
        .o_od_port_bits(od_out), .o_od_port_bits_oe(od_oe), .o_od_rd_data(od_rd),
        .o_alt_rx_chan_a(rxa), .o_alt_rx_chan_b(rxb), .i_se_dir(se_dir),
        .i_se_wr_data(se_dat), .i_se_wr(se_wr), .i_se_timed(se_timed), .i_strobe_en(stb_en),
        .i_strobe_mode(stb_mode), .i_io_cycle(io_cyc), .i_io_rd(io_rd), .i_io_wr(io_wr),
        .i_io_addr(io_addr), .i_strobe_port_bits(se_pin), .o_strobe_port_bits(se_out),
        .o_strobe_port_bits_oe(se_oe), .o_se_rd_data(se_rd), .i_slave_en(slv_en),
        .o_slave_chip_select_n(scs_n), .i_ext_irq0_in_a_en(e0a), .i_ext_irq0_in_b_en(e0b),
        .i_ext_irq1_in_a_en(e1a), .i_ext_irq1_in_b_en(e1b), .i_irq0_edge(edg0),
        .i_irq1_edge(edg1), .i_irq0_clr(clr0), .i_irq1_clr(clr1), .o_irq0_req(req0),
        .o_irq1_req(req1));
    ppde_pin_model u_od_pins (.i_dut_val(od_out), .i_dut_oe(od_oe), .i_ext_val(ext_od),
        .i_ext_en(ext_od_en), .o_pin(od_pin));
    ppde_pin_model u_se_pins (.i_dut_val(se_out), .i_dut_oe(se_oe), .i_ext_val(ext_se),
        .i_ext_en(ext_se_en), .o_pin(se_pin));
    // ****************
    // Clock and helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr_od(input logic [7:0] d);
        od_dat = d;
        od_wr = 1'b1;
        cyc(1);
        od_wr = 1'b0;
    endtask
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        complete_run();
    end
    // ****************
    // Tests
    // ****************
    initial begin
        n_fail = 0; checks = 0; nrst = 1'b0; tevt = 1'b0; od_wr = 1'b0; od_timed = 1'b0;
        txa_en = 1'b0; txb_en = 1'b0; txa = 1'b0; txb = 1'b0; se_wr = 1'b0; se_timed = 1'b0;
        io_cyc = 1'b0; io_rd = 1'b0; io_wr = 1'b0; slv_en = 1'b0; clr0 = 1'b0; clr1 = 1'b0;
        e0a = 1'b0; e0b = 1'b0; e1a = 1'b0; e1b = 1'b0; edg0 = 2'h0; edg1 = 2'h0;
        od_dir = 8'h00; od_odr = 8'h00; od_dat = 8'h00; ext_od = 8'h00; ext_od_en = 8'h00;
        se_dir = 8'h00; se_dat = 8'h00; stb_en = 8'hFF; ext_se = 8'h00; ext_se_en = 8'h00;
        stb_mode = 16'h0000; io_addr = 16'h0000;
        cyc(4);
        nrst = 1'b1;
        cyc(6);
        check("reset oe", od_oe | se_oe, 8'h00);
        check("reset strobes", se_out, 8'hFF);
        check("reset port", od_out, 8'h00);
        check("reset irq", {6'h00, req1, req0}, 8'h00);
        od_dir = 8'hFF;
        wr_od(8'hA5);
        check("push pull", od_out, 8'hA5);
        od_odr = 8'h0F;
        od_dir = 8'h7F;
        cyc(1);
        check("od oe", od_oe, 8'h7A);
        check("od pins", od_rd, 8'hA5);
        od_timed = 1'b1;
        wr_od(8'h3C);
        check("timed hold", od_out & 8'hF0, 8'hA0);
        tevt = 1'b1;
        cyc(1);
        tevt = 1'b0;
        check("timed load", od_out & 8'hF0, 8'h30);
        od_odr = 8'h00; od_dir = 8'h5F; txa_en = 1'b1; txb_en = 1'b1; txa = 1'b1;
        ext_od_en = 8'hA0; ext_od = 8'h80;
        cyc(1);
        check("alt tx", od_out & 8'h50, 8'h40);
        check("alt rx", {6'h00, rxb, rxa}, 8'h01);
        se_dir = 8'hFF; stb_en = 8'hFF;
        for (int m = 0; m < 4; m++) begin
            stb_mode = {8{m[1:0]}};
            for (int k = 0; k < 8; k++) begin
                for (int o = 0; o < 2; o++) begin
                    io_cyc = 1'b1; io_rd = (o == 0); io_wr = (o == 1);
                    io_addr = {k[2:0], 13'h1FFF};
                    act = (m == 0) || (m == 1 && o == 1) || (m == 2 && o == 0) || (m == 3);
                    cyc(1);
                    check("strobe", se_out, act ? ~(8'h01 << k) : 8'hFF);
                    io_cyc = 1'b0; io_rd = 1'b0; io_wr = 1'b0;
                    cyc(1);
                    check("strobe idle", se_out, 8'hFF);
                end
            end
        end
        stb_en = 8'h00; se_timed = 1'b1; se_dat = 8'hA5; se_wr = 1'b1;
        cyc(1);
        se_wr = 1'b0;
        check("se timed hold", se_out, 8'h00);
        tevt = 1'b1;
        cyc(1);
        tevt = 1'b0; se_timed = 1'b0;
        check("se timed load", se_out, 8'hA5);
        stb_en = 8'h00; se_dir = 8'h00; slv_en = 1'b1; ext_se_en = 8'hFF; ext_se = 8'h00;
        cyc(1);
        check("slave sel low", {7'h00, scs_n}, 8'h00);
        ext_se = 8'h80;
        cyc(1);
        check("slave sel high", {7'h00, scs_n}, 8'h01);
        check("se pins", se_rd, 8'h80);
        se_dir = 8'h80; se_dat = 8'h00; se_wr = 1'b1;
        cyc(1);
        se_wr = 1'b0;
        check("slave forced", {7'h00, scs_n}, 8'h00);
        check("se oe", se_oe, 8'h80);
        se_dir = 8'h00; ext_se = 8'h00; slv_en = 1'b0;
        e0a = 1'b1; e0b = 1'b1; e1a = 1'b1; e1b = 1'b1;
        for (int e = 1; e < 4; e++) begin
            edg0 = e[1:0]; edg1 = e[1:0];
            for (int p = 0; p < 8; p++) begin
                if (p == 0 || p == 1 || p == 4 || p == 5) begin
                    ext_se[p] = 1'b1;
                    cyc(2);
                    check("irq early", {6'h00, req1, req0}, 8'h00);
                    cyc(4);
                    check("irq rise", {6'h00, req1, req0},
                          e[1] ? ((p % 2) ? 8'h02 : 8'h01) : 8'h00);
                    clr0 = 1'b1; clr1 = 1'b1;
                    cyc(1);
                    clr0 = 1'b0; clr1 = 1'b0;
                    ext_se[p] = 1'b0;
                    cyc(6);
                    check("irq fall", {6'h00, req1, req0},
                          e[0] ? ((p % 2) ? 8'h02 : 8'h01) : 8'h00);
                    clr0 = 1'b1; clr1 = 1'b1;
                    cyc(1);
                    clr0 = 1'b0; clr1 = 1'b0;
                    cyc(1);
                end
            end
        end
        complete_run();
    end
endmodule // tb_top
